// *** design/density_pkg.sv ***
/*
 * Shared constants and types for the pulse density modulator and its port 2 pin logic.
 * Assumes an APB register bus with 32-bit data and one aligned word per register index.
 */
package density_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam int              ADDR_LSB        = 2;
	localparam int              IDX_W           = 6;
	localparam logic [IDX_W-1:0] IDX_PIN_DATA    = 6'h24;
	localparam logic [IDX_W-1:0] IDX_DIRECTION   = 6'h25;
	localparam logic [IDX_W-1:0] IDX_PULLUP      = 6'h26;
	localparam logic [IDX_W-1:0] IDX_FUNC_SEL    = 6'h27;
	localparam logic [IDX_W-1:0] IDX_PAT_HIGH    = 6'h30;
	localparam logic [IDX_W-1:0] IDX_PAT_LOW     = 6'h31;
	localparam logic [IDX_W-1:0] IDX_PAT2_HIGH   = 6'h32;
	localparam logic [IDX_W-1:0] IDX_PAT2_LOW    = 6'h33;
	localparam logic [IDX_W-1:0] IDX_MOD_CTRL    = 6'h36;

	// Field positions and implemented-bit masks.
	localparam int              BUZZER_BIT      = 7;
	localparam int              PIN5_SEL_BIT    = 6;
	localparam int              PIN2_SEL_BIT    = 4;
	localparam int              ENABLE_BIT      = 4;
	localparam int              DIV_LSB         = 0;
	localparam int              DIV_W           = 3;
	localparam logic [7:0]      FUNC_SEL_MASK   = 8'hD0;
	localparam logic [7:0]      MOD_CTRL_MASK   = 8'h17;
	localparam logic [7:0]      REG_RESET       = 8'h00;

	// Pin numbers with special functions.
	localparam int              PIN_MOD_A       = 2;
	localparam int              PIN_MOD_B       = 5;
	localparam int              PIN_PLAIN       = 6;
	localparam int              PIN_BUZZER      = 7;

	// Modulator structure.
	localparam int              TAPS            = 16;
	localparam int              PRESCALE_W      = 7;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_PIN_DATA, SEL_DIRECTION, SEL_PULLUP, SEL_FUNC_SEL,
		SEL_PAT_HIGH, SEL_PAT_LOW, SEL_PAT2_HIGH, SEL_PAT2_LOW, SEL_MOD_CTRL
	} reg_sel_t;

endpackage

// *** design/density_tap_if.sv ***
/*
 * Carrier between the register block and the tap generator.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/10ps
interface density_tap_if;
	logic                                run;
	logic [density_pkg::DIV_W-1:0]       div_sel;
	logic [density_pkg::TAPS-1:0]        taps;
	logic                                base_tick;

	modport gen (input run, input div_sel, output taps, output base_tick);
	modport user (output run, output div_sel, input taps, input base_tick);
endinterface

// *** design/density_tap_gen.sv ***
/*
 * Base clock divider and binary-weighted tap generator.
 * Assumes run and div_sel come from registers on the same clock.
 */
`timescale 1ns/10ps
module density_tap_gen #(
	parameter int TAP_COUNT = 16
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	density_tap_if.gen         tap_bus
);
	localparam int PW = density_pkg::PRESCALE_W;

	logic [PW-1:0]        pre_q;
	logic [TAP_COUNT-1:0] cnt_q;
	logic [PW-1:0]        div_mask;
	logic                 tick;

	initial begin
		if (TAP_COUNT != density_pkg::TAPS) begin
			$error("TAP_COUNT must match the carrier width");
		end
	end

	// Tick once every 2**div_sel master clocks while running.
	assign div_mask = PW'((8'h01 << tap_bus.div_sel) - 8'h01);
	assign tick     = tap_bus.run && ((pre_q & div_mask) == div_mask);
	assign tap_bus.base_tick = tick;

	// Prescaler restarts when stopped so the first period after enabling is full.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= '0;
		end else if (ce) begin
			pre_q <= tap_bus.run ? pre_q + PW'(1) : '0;
		end
	end

	// Tap counter advances on each base clock tick.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (!tap_bus.run) begin
				cnt_q <= '0;
			end else if (tick) begin
				cnt_q <= cnt_q + TAP_COUNT'(1);
			end
		end
	end

	// Tap k is high when counter bit (15-k) is the lowest set bit, so taps never overlap.
	for (genvar k = 0; k < TAP_COUNT; k++) begin : g_tap
		localparam int POS = TAP_COUNT - 1 - k;
		if (POS == 0) begin : g_top
			assign tap_bus.taps[k] = tap_bus.run && cnt_q[0];
		end else begin : g_low
			assign tap_bus.taps[k] = tap_bus.run && cnt_q[POS] && (cnt_q[POS-1:0] == '0);
		end
	end

	// Helper: cycles since the last tick, for the divider check.
	logic [8:0] gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= '0;
		end else if (ce) begin
			gap_q <= (tick || !tap_bus.run) ? 9'h001 : gap_q + 9'h001;
		end
	end

	divider_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && tick && $past(tick) == 1'b0 && $stable(tap_bus.div_sel) && $past(tap_bus.run) && $past(ce))
		|-> (gap_q == 9'h001 || gap_q == (9'h001 << tap_bus.div_sel)))
		else $error("base tick spacing does not match divider select");

	taps_disjoint_a: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(tap_bus.taps))
		else $error("two taps are high at once");

endmodule

// *** design/density_modulator_port2_mux.sv ***
/*
 * Port 2 pin logic with the pulse density modulator routed onto pins 2 and 5 and a buzzer clock onto pin 7.
 * Assumes an APB master on pclk, a testbench that resolves each pin from out, oe_n and pull-up,
 * and a buzzer clock produced by logic on the same clock.
 */
// Local design decision: register access over APB.
`timescale 1ns/10ps
// What this block does
// - Direction bit 0 makes a pin input, 1 makes it output.
// - Writing the pin data address loads the output latch from the bus.
// - The output latch keeps its value until the next data write.
// - Each pin has a pull-up enable; undriven pulled inputs read as one.
// - Pin 6 is always plain general-purpose input or output.
// - Buzzer enable, mode bit 7, puts the buzzer clock on pin 7.
// - The base clock comes from a divider on the master clock.
// - Divider select n gives master clock divided by two to the n.
// - The base clock is split into sixteen taps, 15 down to 0.
// - Tap 15 runs at half base rate, each lower tap halves again.
// - Output is the OR of taps whose pattern bits are set.
// - Pattern spans 0 to 65535; high density equals pattern over 65536.
// - Pattern is two byte registers, upper and lower, cleared at reset.
// - Module enable decides whether the modulator runs and may reach pin 2.
// - Divider select sits in control bits 2 to 0, enable in bit 4.
// - Mode bit 4 puts the modulator output on pin 2.
// - Mode bit 6 puts the modulator output for the second pattern on pin 5.
module density_modulator_port2_mux #(
	parameter int APB_AW = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        port2_pins_in,
	output logic      [7:0]        port2_pins_out,
	output logic      [7:0]        port2_pins_oe_n,
	output logic      [7:0]        port2_pullup_bits,
	input  wire logic              buzzer_clock
);
	localparam int AW_MIN = density_pkg::ADDR_LSB + density_pkg::IDX_W;

	initial begin
		if (APB_AW < AW_MIN) begin
			$error("APB_AW too narrow for the register map");
		end
	end

	// Register state.
	logic [7:0]  latch_q;
	logic [7:0]  dir_q;
	logic [7:0]  pull_q;
	logic [7:0]  func_q;
	logic [7:0]  pat_hi_q;
	logic [7:0]  pat_lo_q;
	logic [7:0]  pat2_hi_q;
	logic [7:0]  pat2_lo_q;
	logic [7:0]  ctrl_q;
	logic        latch_valid_q;

	// Bus response state.
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// Pin side state.
	logic [7:0]  sync1_q;
	logic [7:0]  sync2_q;
	logic [7:0]  sync3_q;
	logic [7:0]  pin_level_q;
	logic [7:0]  pins_out_q;
	logic [7:0]  pins_oe_n_q;
	logic [7:0]  pull_out_q;

	// Bus decode.
	density_pkg::reg_sel_t sel;
	logic        setup_phase;
	logic        access_done;
	logic        wr_en;
	logic        rd_hit;
	logic [7:0]  rd_byte;

	// Modulator datapath.
	logic [15:0] pattern_word;
	logic [15:0] pattern2_word;
	logic        mod_enable;
	logic        mod_out;
	logic        mod2_out;

	density_tap_if tap_bus ();

	density_tap_gen #(
		.TAP_COUNT (density_pkg::TAPS)
	) u_tap_gen (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.tap_bus   (tap_bus)
	);

	// Maps a word address to the register it names; shared by the read and write paths.
	function automatic density_pkg::reg_sel_t decode(input logic [APB_AW-1:0] addr);
		logic [density_pkg::IDX_W-1:0] idx;
		idx = addr[AW_MIN-1:density_pkg::ADDR_LSB];
		decode = density_pkg::SEL_NONE;
		if (addr[density_pkg::ADDR_LSB-1:0] != '0) begin
			decode = density_pkg::SEL_NONE;
		end else if (APB_AW > AW_MIN && addr[APB_AW-1:AW_MIN-1] > {1'b0, addr[AW_MIN-1]}) begin
			decode = density_pkg::SEL_NONE;
		end else begin
			case (idx)
				density_pkg::IDX_PIN_DATA:  decode = density_pkg::SEL_PIN_DATA;
				density_pkg::IDX_DIRECTION: decode = density_pkg::SEL_DIRECTION;
				density_pkg::IDX_PULLUP:    decode = density_pkg::SEL_PULLUP;
				density_pkg::IDX_FUNC_SEL:  decode = density_pkg::SEL_FUNC_SEL;
				density_pkg::IDX_PAT_HIGH:  decode = density_pkg::SEL_PAT_HIGH;
				density_pkg::IDX_PAT_LOW:   decode = density_pkg::SEL_PAT_LOW;
				density_pkg::IDX_PAT2_HIGH: decode = density_pkg::SEL_PAT2_HIGH;
				density_pkg::IDX_PAT2_LOW:  decode = density_pkg::SEL_PAT2_LOW;
				density_pkg::IDX_MOD_CTRL:  decode = density_pkg::SEL_MOD_CTRL;
				default:                    decode = density_pkg::SEL_NONE;
			endcase
		end
	endfunction

	// A transfer completes on the first access cycle; pready is raised from the setup cycle.
	assign sel         = decode(paddr);
	assign setup_phase = psel && !penable && !pready_q;
	assign access_done = psel && penable && pready_q;
	assign wr_en       = access_done && pwrite && pstrb[0] && (sel != density_pkg::SEL_NONE);
	assign rd_hit      = decode(paddr) != density_pkg::SEL_NONE;

	// Read mux; data reads the filtered pin level and unimplemented bits read as zero.
	always_comb begin
		rd_byte = 8'h00;
		case (sel)
			density_pkg::SEL_PIN_DATA:  rd_byte = pin_level_q;
			density_pkg::SEL_DIRECTION: rd_byte = dir_q;
			density_pkg::SEL_PULLUP:    rd_byte = pull_q;
			density_pkg::SEL_FUNC_SEL:  rd_byte = func_q & density_pkg::FUNC_SEL_MASK;
			density_pkg::SEL_PAT_HIGH:  rd_byte = pat_hi_q;
			density_pkg::SEL_PAT_LOW:   rd_byte = pat_lo_q;
			density_pkg::SEL_PAT2_HIGH: rd_byte = pat2_hi_q;
			density_pkg::SEL_PAT2_LOW:  rd_byte = pat2_lo_q;
			density_pkg::SEL_MOD_CTRL:  rd_byte = ctrl_q & density_pkg::MOD_CTRL_MASK;
			default:                    rd_byte = 8'h00;
		endcase
	end

	// Bus answer: ready, error and data are prepared in the setup cycle; ready and error drop after the access, data holds.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (ce) begin
			if (setup_phase) begin
				pready_q  <= 1'b1;
				pslverr_q <= !rd_hit;
				prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			end else begin
				pready_q  <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// Output latch: only a data write changes it, and it holds otherwise. It has no reset value.
	always_ff @(posedge pclk) begin
		if (ce && wr_en && sel == density_pkg::SEL_PIN_DATA) begin
			latch_q <= pwdata[7:0];
		end
	end

	// Marks the latch as known once written; reset clears it although the latch keeps its value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_valid_q <= 1'b0;
		end else if (ce && wr_en && sel == density_pkg::SEL_PIN_DATA) begin
			latch_valid_q <= 1'b1;
		end
	end

	// Pin configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q  <= density_pkg::REG_RESET;
			pull_q <= density_pkg::REG_RESET;
			func_q <= density_pkg::REG_RESET;
		end else if (ce && wr_en) begin
			case (sel)
				density_pkg::SEL_DIRECTION: dir_q  <= pwdata[7:0];
				density_pkg::SEL_PULLUP:    pull_q <= pwdata[7:0];
				density_pkg::SEL_FUNC_SEL:  func_q <= pwdata[7:0] & density_pkg::FUNC_SEL_MASK;
				default:                    func_q <= func_q;
			endcase
		end
	end

	// Modulator pattern and control registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_hi_q  <= density_pkg::REG_RESET;
			pat_lo_q  <= density_pkg::REG_RESET;
			pat2_hi_q <= density_pkg::REG_RESET;
			pat2_lo_q <= density_pkg::REG_RESET;
			ctrl_q    <= density_pkg::REG_RESET;
		end else if (ce && wr_en) begin
			case (sel)
				density_pkg::SEL_PAT_HIGH:  pat_hi_q  <= pwdata[7:0];
				density_pkg::SEL_PAT_LOW:   pat_lo_q  <= pwdata[7:0];
				density_pkg::SEL_PAT2_HIGH: pat2_hi_q <= pwdata[7:0];
				density_pkg::SEL_PAT2_LOW:  pat2_lo_q <= pwdata[7:0];
				density_pkg::SEL_MOD_CTRL:  ctrl_q    <= pwdata[7:0] & density_pkg::MOD_CTRL_MASK;
				default:                    ctrl_q    <= ctrl_q;
			endcase
		end
	end

	// Tap combination; the all-ones pattern still misses one slot, so full duty is impossible.
	assign pattern_word     = {pat_hi_q, pat_lo_q};
	assign pattern2_word    = {pat2_hi_q, pat2_lo_q};
	assign mod_enable       = ctrl_q[density_pkg::ENABLE_BIT];
	assign tap_bus.run      = mod_enable;
	assign tap_bus.div_sel  = ctrl_q[density_pkg::DIV_LSB +: density_pkg::DIV_W];
	assign mod_out          = |(tap_bus.taps & pattern_word);
	assign mod2_out         = |(tap_bus.taps & pattern2_word);

	// Pin inputs pass three flops; a level is accepted once the last two agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q     <= 8'h00;
			sync2_q     <= 8'h00;
			sync3_q     <= 8'h00;
			pin_level_q <= 8'h00;
		end else if (ce) begin
			sync1_q <= port2_pins_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			for (int i = 0; i < 8; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					pin_level_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Output mux, registered so every pin output comes straight from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_out_q  <= 8'h00;
			pins_oe_n_q <= 8'hFF;
			pull_out_q  <= 8'h00;
		end else if (ce) begin
			pins_out_q  <= latch_q;
			pins_oe_n_q <= ~dir_q;
			pull_out_q  <= pull_q;
			if (func_q[density_pkg::PIN2_SEL_BIT] && mod_enable) begin
				pins_out_q[density_pkg::PIN_MOD_A] <= mod_out;
			end
			if (func_q[density_pkg::PIN5_SEL_BIT]) begin
				pins_out_q[density_pkg::PIN_MOD_B] <= mod2_out;
			end
			if (func_q[density_pkg::BUZZER_BIT]) begin
				pins_out_q[density_pkg::PIN_BUZZER] <= buzzer_clock;
			end
		end
	end

	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign port2_pins_out    = pins_out_q;
	assign port2_pins_oe_n   = pins_oe_n_q;
	assign port2_pullup_bits = pull_out_q;

	// Checks on the bus handshake and on the pin routing.
	sequence setup_s;
		ce && psel && !penable && !pready_q;
	endsequence

	sequence access_s;
		ce && psel && penable && pready;
	endsequence

	property ready_after_setup_p;
		@(posedge pclk) disable iff (!presetn)
		setup_s |=> pready ##1 !pready;
	endproperty

	bus_ready_a: assert property (ready_after_setup_p)
		else $error("pready did not pulse after the setup cycle");

	latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access_s and (pwrite && pstrb[0] && sel == density_pkg::SEL_PIN_DATA))
		|=> latch_q == $past(pwdata[7:0]))
		else $error("pin data write did not load the latch");

	latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_valid_q && !(ce && wr_en && sel == density_pkg::SEL_PIN_DATA)) |=> $stable(latch_q))
		else $error("latch changed without a data write");

	dir_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> port2_pins_oe_n == ~$past(dir_q))
		else $error("output enable does not follow direction");

	pullup_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> port2_pullup_bits == $past(pull_q))
		else $error("pull-up output does not follow its register");

	pin6_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && latch_valid_q) |=> port2_pins_out[density_pkg::PIN_PLAIN] == $past(latch_q[density_pkg::PIN_PLAIN]))
		else $error("pin 6 did not show its latch");

	buzzer_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && func_q[density_pkg::BUZZER_BIT])
		|=> port2_pins_out[density_pkg::PIN_BUZZER] == $past(buzzer_clock))
		else $error("pin 7 did not carry the buzzer clock");

	pin2_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && func_q[density_pkg::PIN2_SEL_BIT] && mod_enable)
		|=> port2_pins_out[density_pkg::PIN_MOD_A] == $past(mod_out))
		else $error("pin 2 did not carry the modulator output");

	pin2_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && latch_valid_q && !(func_q[density_pkg::PIN2_SEL_BIT] && mod_enable))
		|=> port2_pins_out[density_pkg::PIN_MOD_A] == $past(latch_q[density_pkg::PIN_MOD_A]))
		else $error("pin 2 left general-purpose mode while not routed");

	pin5_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && func_q[density_pkg::PIN5_SEL_BIT])
		|=> port2_pins_out[density_pkg::PIN_MOD_B] == $past(mod2_out))
		else $error("pin 5 did not carry the modulator output");

	stopped_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!mod_enable |-> (tap_bus.taps == 16'h0000 && !mod_out))
		else $error("modulator active while disabled");

	fast_tap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && mod_enable && tap_bus.div_sel == 3'h0 && tap_bus.taps[density_pkg::TAPS-1])
		##1 (ce && mod_enable && $stable(tap_bus.div_sel)) |-> !tap_bus.taps[density_pkg::TAPS-1])
		else $error("fastest tap not at half the base rate");

endmodule

// *** verif/density_modulator_port2_mux_tb.sv ***
/*
 * Self-checking testbench for the port 2 pin logic and pulse density modulator.
 * Assumes the design answers APB with one wait-free access cycle and that the bench resolves the pins.
 */
`timescale 1ns/10ps
module density_modulator_port2_mux_tb;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, buzz, bz_prev, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [3:0]  pstrb;
	logic [7:0]  pins_in, pins_out, oe_n, pu, ext, dir, dat, pul;
	logic [15:0] pat;
	int          bad_count, cmp_count, cyc, hi, ri;

	density_modulator_port2_mux i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port2_pins_in(pins_in), .port2_pins_out(pins_out), .port2_pins_oe_n(oe_n),
		.port2_pullup_bits(pu), .buzzer_clock(buzz));

	// The wire: a driven pin shows the design, a pulled pin reads high, else the outside level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pins_in[i] = !oe_n[i] ? pins_out[i] : (pu[i] ? 1'b1 : ext[i]);
		end
	end

	// Clock at 250 MHz.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Cycle count guards against a hang, and the buzzer source wanders irregularly.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		buzz <= cyc[0] ^ cyc[3];
		if (cyc == 100000) begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function automatic logic [7:0] pin_read(input logic [7:0] d, v, p, e);
		return (d & v) | (~d & p) | (~d & ~p & e);
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {4'h0, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic count(input int n, input int b);
		logic p;
		hi = 0;
		ri = 0;
		@(negedge pclk);
		p = pins_out[b];
		repeat (n) begin
			@(negedge pclk);
			if (pins_out[b] === 1'b1) hi++;
			if (pins_out[b] === 1'b1 && p !== 1'b1) ri++;
			p = pins_out[b];
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence: reset, register map, pins, buzzer, modulator density and divider.
	initial begin
		{presetn, ce, psel, penable, pwrite, paddr, pwdata, ext, cyc, bad_count, cmp_count} = '0;
		pstrb = 4'h1;
		ce = 1'b1;
		buzz = 1'b0;
		seed = 32'h78A4;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, (i < 3) ? 6'h25 + 6'(i) : (i < 7) ? 6'h2D + 6'(i) : 6'h36, 8'h00);
			check("reset value", rd, 32'h0);
		end
		check("oe_n reset", {24'h0, oe_n}, 32'hFF);
		check("pullup reset", {24'h0, pu}, 32'h0);
		apb(1'b0, 6'h3F, 8'h00);
		check("unmapped err", {31'h0, err}, 32'h1);
		// Pins go to output before any routing bit is set, as software must do.
		apb(1'b1, 6'h25, 8'hFF);
		apb(1'b1, 6'h27, 8'hFF);
		apb(1'b0, 6'h27, 8'h00);
		check("func mask", rd, 32'hD0);
		apb(1'b1, 6'h36, 8'hFF);
		apb(1'b0, 6'h36, 8'h00);
		check("ctrl mask", rd, 32'h17);
		apb(1'b1, 6'h27, 8'h00);
		apb(1'b1, 6'h36, 8'h00);
		for (int k = 0; k < 8; k++) begin
			seed = xs(seed);
			{dir, dat, pul} = seed[31:8];
			ext <= seed[7:0];
			if (k == 0) dir = 8'h00;
			apb(1'b1, 6'h24, dat);
			apb(1'b1, 6'h25, dir);
			apb(1'b1, 6'h26, pul);
			repeat (6) @(posedge pclk);
			check("oe_n", {24'h0, oe_n}, {24'h0, ~dir});
			check("pullup", {24'h0, pu}, {24'h0, pul});
			check("latch", {24'h0, pins_out}, {24'h0, dat});
			apb(1'b0, 6'h24, 8'h00);
			check("pin read", rd, {24'h0, pin_read(dir, dat, pul, ext)});
		end
		apb(1'b1, 6'h25, 8'hFF);
		apb(1'b1, 6'h24, 8'h40);
		apb(1'b1, 6'h27, 8'hD0);
		apb(1'b1, 6'h30, 8'hFF);
		// Pins are looked at mid-cycle, where the value launched at the last edge has settled.
		@(negedge pclk);
		for (int k = 0; k < 32; k++) begin
			bz_prev = buzz;
			@(negedge pclk);
			check("buzzer pin", {31'h0, pins_out[7]}, {31'h0, bz_prev});
			check("plain pin", {31'h0, pins_out[6]}, 32'h1);
			check("pin2 disabled", {31'h0, pins_out[2]}, 32'h0);
			check("pin5 idle", {31'h0, pins_out[5]}, 32'h0);
		end
		seed = xs(seed);
		pat = seed[15:0] | 16'h0001;
		apb(1'b1, 6'h30, pat[15:8]);
		apb(1'b1, 6'h31, pat[7:0]);
		apb(1'b1, 6'h32, 8'h80);
		apb(1'b1, 6'h33, 8'h00);
		apb(1'b0, 6'h31, 8'h00);
		check("pattern low", rd, {24'h0, pat[7:0]});
		apb(1'b1, 6'h36, 8'h10);
		count(65536, 2);
		check("density", hi, pat);
		count(64, 5);
		check("pin5 density", hi, 32);
		// With the enable low nothing may move; the tap generator is held too, so pin 5 stops toggling every cycle.
		@(posedge pclk);
		ce <= 1'b0;
		@(negedge pclk);
		dat = pins_out;
		repeat (16) begin
			@(negedge pclk);
			check("ce freeze", {24'h0, pins_out}, {24'h0, dat});
		end
		@(posedge pclk);
		ce <= 1'b1;
		apb(1'b1, 6'h30, 8'h40);
		apb(1'b1, 6'h31, 8'h00);
		for (int d = 0; d < 8; d++) begin
			apb(1'b1, 6'h36, 8'h00);
			apb(1'b1, 6'h36, 8'h10 | 8'(d));
			count(2048, 2);
			check("tap14 rate", ri, 2048 >> (d + 2));
		end
		apb(1'b1, 6'h36, 8'h00);
		count(64, 2);
		check("disabled out", hi, 0);
		// Full duty is reached only by plain output driven high.
		apb(1'b1, 6'h27, 8'h00);
		apb(1'b1, 6'h24, 8'h44);
		count(64, 2);
		check("full duty", hi, 64);
		// A second reset in mid-run must clear what software wrote, except the output latch, which keeps its value.
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 6'h30, 8'h00);
		check("pattern cleared", rd, 32'h0);
		apb(1'b0, 6'h25, 8'h00);
		check("direction cleared", rd, 32'h0);
		check("oe_n cleared", {24'h0, oe_n}, 32'hFF);
		check("pullup cleared", {24'h0, pu}, 32'h0);
		pstrb <= 4'h0;
		apb(1'b1, 6'h25, 8'hA5);
		pstrb <= 4'h1;
		apb(1'b0, 6'h25, 8'h00);
		check("strobe off", rd, 32'h0);
		summarize();
	end
endmodule
